/* File: logic/cfl_buf.sv */
// Small valid/ready FIFO used in the readback output path
`timescale 1ns/1ps
module cfl_buf #(
   parameter int W = 1,
   parameter int D = 2
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam logic [PW-1:0] PTR_LAST = PW'(D - 1);
   localparam logic [PW:0]   CNT_FULL = (PW+1)'(D);

   logic [W-1:0]  mem_r [D];
   logic [PW-1:0] wr_ptr_r;
   logic [PW-1:0] rd_ptr_r;
   logic [PW:0]   cnt_r;
   logic          full_r;
   logic          empty_r;

   wire           push    = in_valid && !full_r;
   wire           pop     = out_ready && !empty_r;
   wire [PW-1:0]  wr_nxt  = (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
   wire [PW-1:0]  rd_nxt  = (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
   wire [PW:0]    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);

   assign in_ready  = !full_r;
   assign out_valid = !empty_r;
   assign out_data  = mem_r[rd_ptr_r];

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
         full_r   <= 1'b0;
         empty_r  <= 1'b1;
      end else if (clk_en) begin
         if (push) wr_ptr_r <= wr_nxt;
         if (pop) rd_ptr_r <= rd_nxt;
         cnt_r   <= cnt_nxt;
         full_r  <= (cnt_nxt == CNT_FULL);
         empty_r <= (cnt_nxt == '0);
      end
   end

   always_ff @(posedge clock) begin
      if (clk_en && push) mem_r[wr_ptr_r] <= in_data;
   end

endmodule

/* File: logic/cfl_loader.sv */
// Configuration frame loader with power-up clear and readback checksum
// What this block does
// - Each frame is one start bit, data bits, then four check bits.
// - Frame length is 13 per row plus 9, 17, 8, start and check.
// - Frame count is 47 per column plus 27, 52 and 4.
// - After the last frame come 5 postamble bits, or 8 for small family.
// - Leading one bits before the header are ignored.
// - With checking off, ones after the check bits are skipped.
// - A failed frame check stops loading, pulls init low, waits.
// - Readback ends with the top eleven bits of the 16-bit checksum.
// - Readback checksum is serial CRC-16 with the CCITT polynomial.
// - Power-up runs clear, initialization, loading, start-up in order.
// - Delay starts only after the sample bit write-read test passes.
// - Power-up delay is nominally 16 ms.
// - Mode bit zero low makes the power-up delay four times longer.
// - Reconfiguration request skips the long power-up delay.
// - During the delay, memory clear cycles through frames; a held request keeps it at frame 0.
// - Mode inputs are sampled two clocks after init is seen high.
// - Header holds preamble 0010 then a 24-bit clock count.
`timescale 1ns/1ps
module cfl_loader #(
   parameter int POR_DELAY_CYCLES = cfl_pkg::POR_DELAY_CYC
) (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   clk_en,
   input  wire logic                   por_test_ok,
   input  wire logic                   program_req_n,
   input  wire logic                   mode_select_bit0,
   input  wire logic                   mode_select_bit1,
   input  wire logic                   mode_select_bit2,
   input  wire logic                   small_family,
   input  wire logic                   crc_enable,
   input  wire logic                   init_in,
   output logic                        init_out,
   output logic                        init_oe,
   input  wire logic                   cfg_bit,
   input  wire logic                   cfg_bit_valid,
   output logic                        mem_bit,
   output logic                        mem_valid,
   output logic [cfl_pkg::FR_W-1:0]    mem_frame,
   output logic [cfl_pkg::FR_W-1:0]    clr_frame,
   output logic                        clr_we,
   output logic [2:0]                  mode,
   output cfl_pkg::cfl_phase_t         phase,
   output logic                        done,
   output logic                        cfg_error,
   input  wire logic                   rb_start,
   input  wire logic                   rb_bit,
   input  wire logic                   rb_bit_valid,
   input  wire logic                   rb_last,
   output logic                        rb_ready,
   output logic                        rb_accepting,
   output logic                        rb_out_bit,
   output logic                        rb_out_valid,
   input  wire logic                   rb_out_ready
);
   import cfl_pkg::*;

   typedef enum logic [3:0] {
      S_POR_TEST, S_CLEAR, S_LAST_PASS, S_INIT_WAIT, S_MODE_WAIT,
      S_HDR_HUNT, S_PREAMBLE, S_LENGTH, S_FRAME_HUNT, S_FRAME_DATA,
      S_FRAME_CHECK, S_POSTAMBLE, S_LEN_WAIT, S_STARTUP, S_ERR_WAIT
   } cfl_state_t;

   typedef enum logic [1:0] {RB_IDLE, RB_DATA, RB_TAIL} cfl_rb_t;

   localparam logic [DLY_W-1:0] DLY_NORM   = DLY_W'(POR_DELAY_CYCLES);
   localparam logic [DLY_W-1:0] DLY_MASTER =
      DLY_W'(POR_DELAY_CYCLES * MASTER_MULT);

   cfl_state_t              state_r, state_nxt;
   logic [DLY_W-1:0]        dly_r, dly_nxt;
   logic [FR_W-1:0]         clr_r, clr_nxt;
   logic [FR_W-1:0]         frame_r, frame_nxt;
   logic [FB_W-1:0]         cnt_r, cnt_nxt;
   logic [LEN_BITS-1:0]     len_r, len_nxt;
   logic [LEN_BITS-1:0]     clk_cnt_r, clk_cnt_nxt;
   logic [3:0]              chk_r, chk_nxt;
   logic [3:0]              rx_chk_r, rx_chk_nxt;
   logic [2:0]              mode_r, mode_nxt;
   logic                    init_low_r, init_low_nxt;
   logic                    err_r, err_nxt;
   logic                    done_r, done_nxt;
   logic                    we_r, we_nxt;
   logic                    mv_r, mv_nxt;
   logic                    mbit_r, mbit_nxt;
   cfl_phase_t              phase_r, phase_nxt;
   logic                    init_out_r;

   // Frame check step and loader decode helpers
   wire                     chk_fb    = chk_r[3] ^ cfg_bit;
   wire [3:0]               chk_step  = {chk_r[2:0], 1'b0}
                                        ^ (chk_fb ? CHK_POLY : 4'h0);
   wire [3:0]               rx_full   = {rx_chk_r[2:0], cfg_bit};
   wire                     pass_end  = (clr_r == FRAME_LAST);
   wire                     pre_bit   = PREAMBLE[2'(PRE_LAST - cnt_r)];
   wire [FB_W-1:0]          post_last = small_family ? POST_SMALL_LAST
                                                     : POST_LARGE_LAST;
   wire                     load_st   = (state_r >= S_HDR_HUNT)
                                        && (state_r <= S_LEN_WAIT);
   wire                     v         = cfg_bit_valid;

   assign phase_nxt = (state_nxt <= S_LAST_PASS) ? PH_CLEAR :
                      (state_nxt <= S_MODE_WAIT) ? PH_INIT :
                      (state_nxt == S_STARTUP)   ? PH_STARTUP : PH_LOAD;

   always_comb begin
      state_nxt    = state_r;
      dly_nxt      = dly_r;
      clr_nxt      = clr_r;
      frame_nxt    = frame_r;
      cnt_nxt      = cnt_r;
      len_nxt      = len_r;
      clk_cnt_nxt  = clk_cnt_r;
      chk_nxt      = chk_r;
      rx_chk_nxt   = rx_chk_r;
      mode_nxt     = mode_r;
      init_low_nxt = init_low_r;
      err_nxt      = err_r;
      done_nxt     = done_r;
      we_nxt       = 1'b0;
      mv_nxt       = 1'b0;
      mbit_nxt     = mbit_r;
      // Padding ones are clocks too, so they count toward the length
      if (load_st && v) clk_cnt_nxt = clk_cnt_r + 1'b1;
      case (state_r)
         S_POR_TEST: begin
            init_low_nxt = 1'b1;
            if (por_test_ok) begin
               dly_nxt   = mode_select_bit0 ? DLY_NORM : DLY_MASTER;
               clr_nxt   = '0;
               state_nxt = S_CLEAR;
            end
         end
         S_CLEAR: begin
            init_low_nxt = 1'b1;
            we_nxt  = 1'b1;
            clr_nxt = pass_end ? '0 : clr_r + 1'b1;
            if (dly_r != '0) dly_nxt = dly_r - 1'b1;
            if (pass_end && dly_r == '0 && program_req_n) begin
               state_nxt = S_LAST_PASS;
            end
         end
         S_LAST_PASS: begin
            we_nxt  = 1'b1;
            clr_nxt = pass_end ? '0 : clr_r + 1'b1;
            if (pass_end) begin
               init_low_nxt = 1'b0;
               state_nxt    = S_INIT_WAIT;
            end
         end
         S_INIT_WAIT: begin
            if (init_in) begin
               cnt_nxt   = '0;
               state_nxt = S_MODE_WAIT;
            end
         end
         S_MODE_WAIT: begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_r == MODE_LAST) begin
               mode_nxt    = {mode_select_bit2, mode_select_bit1,
                              mode_select_bit0};
               clk_cnt_nxt = '0;
               state_nxt   = S_HDR_HUNT;
            end
         end
         S_HDR_HUNT: begin
            // Ones ahead of the preamble are padding and are dropped
            if (v && !cfg_bit) begin
               cnt_nxt   = FB_W'(1);
               state_nxt = S_PREAMBLE;
            end
         end
         S_PREAMBLE: begin
            if (v) begin
               cnt_nxt = cnt_r + 1'b1;
               if (cfg_bit != pre_bit) begin
                  state_nxt = S_HDR_HUNT;
               end else if (cnt_r == PRE_LAST) begin
                  cnt_nxt   = '0;
                  state_nxt = S_LENGTH;
               end
            end
         end
         S_LENGTH: begin
            if (v) begin
               len_nxt = {len_r[LEN_BITS-2:0], cfg_bit};
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == LEN_LAST) begin
                  frame_nxt = '0;
                  state_nxt = S_FRAME_HUNT;
               end
            end
         end
         S_FRAME_HUNT: begin
            if (v && !cfg_bit) begin
               cnt_nxt   = '0;
               chk_nxt   = CHK_INIT;
               state_nxt = S_FRAME_DATA;
            end else if (v && crc_enable && frame_r != '0) begin
               err_nxt      = 1'b1;
               init_low_nxt = 1'b1;
               state_nxt    = S_ERR_WAIT;
            end
         end
         S_FRAME_DATA: begin
            if (v) begin
               mv_nxt   = 1'b1;
               mbit_nxt = cfg_bit;
               chk_nxt  = chk_step;
               cnt_nxt  = cnt_r + 1'b1;
               if (cnt_r == DATA_LAST) begin
                  cnt_nxt   = '0;
                  state_nxt = S_FRAME_CHECK;
               end
            end
         end
         S_FRAME_CHECK: begin
            if (v) begin
               rx_chk_nxt = rx_full;
               cnt_nxt    = cnt_r + 1'b1;
               if (cnt_r == CHECK_LAST) begin
                  cnt_nxt = '0;
                  if (crc_enable && rx_full != chk_r) begin
                     err_nxt      = 1'b1;
                     init_low_nxt = 1'b1;
                     state_nxt    = S_ERR_WAIT;
                  end else if (frame_r == FRAME_LAST) begin
                     state_nxt = S_POSTAMBLE;
                  end else begin
                     frame_nxt = frame_r + 1'b1;
                     state_nxt = S_FRAME_HUNT;
                  end
               end
            end
         end
         S_POSTAMBLE: begin
            if (v) begin
               cnt_nxt = cnt_r + 1'b1;
               if (cnt_r == post_last) state_nxt = S_LEN_WAIT;
            end
         end
         S_LEN_WAIT: begin
            if (clk_cnt_r >= len_r) begin
               done_nxt  = 1'b1;
               state_nxt = S_STARTUP;
            end
         end
         S_STARTUP: begin
            done_nxt = 1'b1;
         end
         S_ERR_WAIT: begin
            init_low_nxt = 1'b1;
         end
         default: begin
            state_nxt = S_POR_TEST;
         end
      endcase
      // A request in any state but S_POR_TEST restarts clearing at once and never reloads the delay
      if (!program_req_n && state_r != S_POR_TEST) begin
         state_nxt    = S_CLEAR;
         dly_nxt      = '0;
         clr_nxt      = '0;
         init_low_nxt = 1'b1;
         done_nxt     = 1'b0;
         err_nxt      = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r    <= S_POR_TEST;
         dly_r      <= '0;
         clr_r      <= '0;
         frame_r    <= '0;
         cnt_r      <= '0;
         len_r      <= '0;
         clk_cnt_r  <= '0;
         chk_r      <= CHK_INIT;
         rx_chk_r   <= '0;
      end else if (clk_en) begin
         state_r    <= state_nxt;
         dly_r      <= dly_nxt;
         clr_r      <= clr_nxt;
         frame_r    <= frame_nxt;
         cnt_r      <= cnt_nxt;
         len_r      <= len_nxt;
         clk_cnt_r  <= clk_cnt_nxt;
         chk_r      <= chk_nxt;
         rx_chk_r   <= rx_chk_nxt;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_r     <= '0;
         init_low_r <= 1'b1;
         err_r      <= 1'b0;
         done_r     <= 1'b0;
         we_r       <= 1'b0;
         mv_r       <= 1'b0;
         mbit_r     <= 1'b0;
         phase_r    <= PH_CLEAR;
         init_out_r <= 1'b0;
      end else if (clk_en) begin
         mode_r     <= mode_nxt;
         init_low_r <= init_low_nxt;
         err_r      <= err_nxt;
         done_r     <= done_nxt;
         we_r       <= we_nxt;
         mv_r       <= mv_nxt;
         mbit_r     <= mbit_nxt;
         phase_r    <= phase_nxt;
      end
   end

   // Open-drain init: only ever driven low
   assign init_out  = init_out_r;
   assign init_oe   = init_low_r;
   assign mem_bit   = mbit_r;
   assign mem_valid = mv_r;
   assign mem_frame = frame_r;
   assign clr_frame = clr_r;
   assign clr_we    = we_r;
   assign mode      = mode_r;
   assign phase     = phase_r;
   assign done      = done_r;
   assign cfg_error = err_r;

   // Readback path; the buffer lets a stalled reader lose no bit
   cfl_rb_t                 rb_r, rb_nxt;
   logic [CRC_W-1:0]        crc_r;
   logic [3:0]              tail_r;
   logic                    buf_ready;

   wire                     rb_take   = (rb_r == RB_DATA) && rb_bit_valid
                                        && buf_ready;
   wire                     tail_push = (rb_r == RB_TAIL) && buf_ready;
   wire                     crc_fb    = crc_r[CRC_TOP] ^ rb_bit;
   wire [CRC_W-1:0]         crc_step  = {crc_r[CRC_W-2:0], 1'b0}
                                        ^ (crc_fb ? CRC_POLY : CRC_INIT);
   wire                     buf_data  = (rb_r == RB_TAIL)
                                        ? crc_r[4'(CRC_TOP - tail_r)]
                                        : rb_bit;
   wire                     rb_start_ok = (rb_r == RB_IDLE) && rb_start;

   assign rb_nxt = rb_start_ok                              ? RB_DATA :
                   (rb_take && rb_last)                     ? RB_TAIL :
                   (tail_push && tail_r == RB_TAIL_LAST)    ? RB_IDLE :
                                                              rb_r;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rb_r   <= RB_IDLE;
         crc_r  <= CRC_INIT;
         tail_r <= '0;
      end else if (clk_en) begin
         rb_r <= rb_nxt;
         if (rb_start_ok) crc_r <= CRC_INIT;
         else if (rb_take) crc_r <= crc_step;
         if (rb_take) tail_r <= '0;
         else if (tail_push) tail_r <= tail_r + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) rb_accepting <= 1'b0;
      else if (clk_en) rb_accepting <= (rb_nxt == RB_DATA);
   end

   assign rb_ready = buf_ready;

   cfl_buf #(.W(BUF_W), .D(BUF_DEPTH)) u_rb_buf (
      .clock     (clock),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .in_valid  (rb_take || tail_push),
      .in_data   (buf_data),
      .in_ready  (buf_ready),
      .out_valid (rb_out_valid),
      .out_data  (rb_out_bit),
      .out_ready (rb_out_ready)
   );

   a_check_init_low: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(err_r) |-> init_oe && state_r == S_ERR_WAIT)
      else $error("check error without init low");
   a_frame_data_len: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == S_FRAME_CHECK && $past(state_r) == S_FRAME_DATA
      |-> $past(cnt_r) == DATA_LAST)
      else $error("frame data length wrong");
   a_mode_sample_time: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == S_MODE_WAIT && $past(state_r) == S_INIT_WAIT && clk_en
      |=> ##[0:300] state_r == S_HDR_HUNT)
      else $error("mode sampling late");
   a_por_delay_load: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == S_CLEAR && $past(state_r) == S_POR_TEST
      |-> dly_r == ($past(mode_select_bit0) ? DLY_NORM : DLY_MASTER))
      else $error("power-up delay length wrong");
   a_request_skips: assert property (@(posedge clock) disable iff (!rst_n)
      !program_req_n && clk_en && state_r != S_POR_TEST
      |=> state_r == S_CLEAR && dly_r == '0 && init_oe)
      else $error("request did not restart clear");
   a_clear_held: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == S_CLEAR && (dly_r != '0 || !program_req_n)
      |=> state_r == S_CLEAR)
      else $error("left clear too early");
   a_crc_restart: assert property (@(posedge clock) disable iff (!rst_n)
      rb_start_ok && clk_en |=> crc_r == CRC_INIT)
      else $error("checksum not cleared");
   a_tail_count: assert property (@(posedge clock) disable iff (!rst_n)
      rb_r == RB_IDLE && $past(rb_r) == RB_TAIL
      |-> $past(tail_r) == RB_TAIL_LAST)
      else $error("checksum tail length wrong");
   a_postamble_len: assert property (@(posedge clock) disable iff (!rst_n)
      state_r == S_LEN_WAIT && $past(state_r) == S_POSTAMBLE
      |-> $past(cnt_r) == $past(post_last))
      else $error("postamble length wrong");

endmodule

/* File: logic/cfl_pkg.sv */
// Shared constants and types for the configuration frame loader
package cfl_pkg;

   localparam int CLK_HZ        = 50_000_000;
   localparam int POR_DELAY_MS  = 16;
   localparam int POR_DELAY_CYC = POR_DELAY_MS * (CLK_HZ / 1000);
   localparam int MASTER_MULT   = 4;
   localparam int DLY_W         = 24;

   localparam int ROWS          = 20;
   localparam int COLS          = 20;
   localparam int ROW_BITS      = 13;
   localparam int TOP_BITS      = 9;
   localparam int BOT_BITS      = 17;
   localparam int EXTRA_BITS    = 8;
   localparam int START_BITS    = 1;
   localparam int CHECK_BITS    = 4;
   localparam int BITS_PER_FRAME = ROW_BITS * ROWS + TOP_BITS + BOT_BITS
                                 + EXTRA_BITS + START_BITS + CHECK_BITS;
   localparam int COL_FRAMES    = 47;
   localparam int LEFT_FRAMES   = 27;
   localparam int RIGHT_FRAMES  = 52;
   localparam int EXTRA_FRAMES  = 4;
   localparam int FRAMES        = COL_FRAMES * COLS + LEFT_FRAMES
                                 + RIGHT_FRAMES + EXTRA_FRAMES;
   localparam int POST_LARGE    = 5;
   localparam int POST_SMALL    = 8;

   localparam int FB_W          = 10;
   localparam int FR_W          = 11;
   localparam int LEN_BITS      = 24;
   localparam int PRE_BITS      = 4;
   localparam int MODE_SAMPLE_CLKS = 2;

   localparam logic [FB_W-1:0] DATA_LAST =
      FB_W'(BITS_PER_FRAME - START_BITS - CHECK_BITS - 1);
   localparam logic [FB_W-1:0] CHECK_LAST = FB_W'(CHECK_BITS - 1);
   localparam logic [FB_W-1:0] PRE_LAST   = FB_W'(PRE_BITS - 1);
   localparam logic [FB_W-1:0] LEN_LAST   = FB_W'(LEN_BITS - 1);
   localparam logic [FB_W-1:0] MODE_LAST  = FB_W'(MODE_SAMPLE_CLKS - 1);
   localparam logic [FB_W-1:0] POST_LARGE_LAST = FB_W'(POST_LARGE - 1);
   localparam logic [FB_W-1:0] POST_SMALL_LAST = FB_W'(POST_SMALL - 1);
   localparam logic [FR_W-1:0] FRAME_LAST = FR_W'(FRAMES - 1);

   localparam logic [PRE_BITS-1:0] PREAMBLE = 4'h2;
   localparam logic [3:0]  CHK_POLY  = 4'h3;
   localparam logic [3:0]  CHK_INIT  = 4'h0;
   localparam int          CRC_W     = 16;
   localparam logic [15:0] CRC_POLY  = 16'h1021;
   localparam logic [15:0] CRC_INIT  = 16'h0000;
   localparam int          RB_CRC_BITS = 11;
   localparam logic [3:0]  RB_TAIL_LAST = 4'(RB_CRC_BITS - 1);
   localparam logic [3:0]  CRC_TOP   = 4'(CRC_W - 1);

   localparam int BUF_W     = 1;
   localparam int BUF_DEPTH = 2;

   typedef enum logic [1:0] {
      PH_CLEAR,
      PH_INIT,
      PH_LOAD,
      PH_STARTUP
   } cfl_phase_t;

endpackage

/* File: test/cfl_src.sv */
// Configuration data source and pulled-up shared init wire
`timescale 1ns/1ps
module cfl_src (
   input  wire logic clock,
   input  wire logic init_oe,
   output logic      init_in,
   output logic      cfg_bit,
   output logic      cfg_bit_valid
);
   initial begin
      cfg_bit = 1'b0;
      cfg_bit_valid = 1'b0;
   end
   // Pull-up wins unless a party drives the wire low
   assign init_in = ~init_oe;
   // Serial bits MSB first; the data line toggles once released
   task automatic send(input logic [63:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(posedge clock);
         cfg_bit <= v[i];
         cfg_bit_valid <= 1'b1;
      end
      @(posedge clock);
      cfg_bit <= ~cfg_bit;
      cfg_bit_valid <= 1'b0;
   endtask
endmodule

/* File: test/test_cfl_loader.sv */
// Self-checking bench for the configuration frame loader
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin \
   n_mismatch++; $display("mismatch at %0t: %s", $time, m); end end
module test_cfl_loader;
   import cfl_pkg::*;
   logic clock, rst_n, clk_en, por_test_ok, program_req_n, small_family;
   logic crc_enable, mode_select_bit0, mode_select_bit1, mode_select_bit2;
   logic init_in, init_out, init_oe, cfg_bit, cfg_bit_valid, mem_bit;
   logic mem_valid, clr_we, done, cfg_error, rb_start, rb_bit, rb_last;
   logic rb_bit_valid, rb_ready, rb_accepting, rb_out_bit, rb_out_valid;
   logic rb_out_ready;
   logic [FR_W-1:0] mem_frame, clr_frame;
   logic [2:0]      mode;
   cfl_phase_t      phase;
   int              n_mismatch, checks_done, n_mv, n_one;
   // Delay below one normal pass, and master delay between one and two passes
   cfl_loader #(.POR_DELAY_CYCLES(300)) i_cfl_loader (.*);
   cfl_src i_cfl_src (.*);
   always @(negedge clock) begin
      if (mem_valid === 1'b1) begin
         n_mv++;
         n_one += (mem_bit === 1'b1);
      end
   end
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Wait for init release, then expect the mode inputs captured
   task automatic wait_init(input logic [2:0] m, input int lo, input int hi);
      int n;
      n = 0;
      while (init_oe !== 1'b0 && n < 5000) begin
         @(negedge clock);
         n++;
      end
      `CHK(n > lo && n < hi, 1'b1, "clear length")
      repeat (4) @(negedge clock);
      `CHK(mode, m, "mode capture")
   endtask
   task automatic t_power();
      @(posedge clock);
      por_test_ok <= 1'b1;
      repeat (3) @(negedge clock);
      `CHK(clr_we, 1'b1, "clear running")
      `CHK(clr_frame, 11'h001, "clear address steps")
      wait_init(3'h5, 1023, 2200);
   endtask
   task automatic t_frame(input logic [48:0] dat, input logic [3:0] chk);
      i_cfl_src.send(64'h0, 1);
      for (int k = 0; k < 6; k++) i_cfl_src.send(64'(dat), 49);
      i_cfl_src.send(64'(chk), 4);
      repeat (3) @(negedge clock);
   endtask
   task automatic t_load();
      int nd;
      nd = BITS_PER_FRAME - START_BITS - CHECK_BITS;
      i_cfl_src.send(64'hFF, 8);
      i_cfl_src.send(64'h2, 4);
      // Length left at its maximum, so no pad can outrun it
      i_cfl_src.send(64'hFFFFFF, 24);
      t_frame(49'h0, 4'h0);
      `CHK(cfg_error, 1'b0, "good frame")
      `CHK(mem_frame, 11'h001, "frame index")
      `CHK(n_mv, nd, "data bits per frame")
      `CHK(n_one, 0, "zero data bits")
      @(posedge clock);
      crc_enable <= 1'b0;
      i_cfl_src.send(64'hF, 4);
      t_frame({49{1'b1}}, 4'hF);
      `CHK(cfg_error, 1'b0, "pad ones with check off")
      `CHK(mem_frame, 11'h002, "second frame index")
      `CHK(n_one, nd, "one data bits")
      @(posedge clock);
      crc_enable <= 1'b1;
      t_frame(49'h0, 4'hF);
      `CHK(cfg_error, 1'b1, "bad frame flag")
      `CHK(init_oe, 1'b1, "init pulled low")
      `CHK(init_out, 1'b0, "init drives low")
      `CHK(done, 1'b0, "no start-up after error")
   endtask
   task automatic t_readback();
      logic [15:0] d, c;
      logic [26:0] got;
      d = 16'hA5C3;
      c = 16'h0000;
      for (int i = 15; i >= 0; i--)
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
      for (int r = 0; r < 2; r++) begin
         @(posedge clock);
         rb_start <= 1'b1;
         @(posedge clock);
         rb_start <= 1'b0;
         fork
            for (int i = 15; i >= 0; i--) begin
               rb_bit <= d[i];
               rb_bit_valid <= 1'b1;
               rb_last <= (i == 0);
               do @(negedge clock); while (!(rb_ready && rb_accepting));
               @(posedge clock);
            end
            begin
               repeat (12) @(negedge clock);
               `CHK(rb_ready, 1'b0, "buffer full on stall")
               @(posedge clock);
               rb_out_ready <= 1'b1;
               for (int k = 26; k >= 0; k--) begin
                  do @(negedge clock); while (rb_out_valid !== 1'b1);
                  got[k] = rb_out_bit;
                  @(posedge clock);
               end
            end
         join
         rb_bit_valid <= 1'b0;
         rb_out_ready <= 1'b0;
         `CHK(got, {d, c[15:5]}, "readback tail")
      end
   endtask
   task automatic t_reconfig();
      @(posedge clock);
      program_req_n <= 1'b0;
      {mode_select_bit2, mode_select_bit1, mode_select_bit0} <= 3'h2;
      repeat (3) @(posedge clock);
      program_req_n <= 1'b1;
      @(negedge clock);
      `CHK(phase, PH_CLEAR, "request clears")
      `CHK(cfg_error, 1'b0, "error cleared")
      wait_init(3'h2, 1023, 2200);
   endtask
   // Second power-up in mid-run, master mode selected
   task automatic t_master();
      @(posedge clock);
      rst_n <= 1'b0;
      @(negedge clock);
      `CHK(init_oe, 1'b1, "init low in reset")
      `CHK(rb_ready, 1'b1, "buffer ready in reset")
      `CHK(phase, PH_CLEAR, "phase in reset")
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      @(negedge clock);
      `CHK(clr_we, 1'b0, "no clear before test")
      wait_init(3'h2, 2200, 3300);
   endtask
   initial begin
      {rst_n, por_test_ok, small_family, rb_start, rb_bit} = 5'h00;
      {rb_bit_valid, rb_last, rb_out_ready} = 3'h0;
      {clk_en, crc_enable, program_req_n} = 3'h7;
      {mode_select_bit2, mode_select_bit1, mode_select_bit0} = 3'h5;
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      t_power();
      t_load();
      t_readback();
      t_reconfig();
      t_master();
      conclude();
   end
   initial begin
      #400000;
      n_mismatch++;
      conclude();
   end
endmodule
